// ---- rtl/tw_bus_control.sv ----
// Register and control engine of the byte-oriented two-wire serial unit
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

// How it works
// [R1] Own address or enabled general call match sets the job-done flag
// [R2] A completed received data byte sets the job-done flag
// [R3] STOP or repeated START while addressed as slave sets job-done
// [R4] START or STOP at an illegal position is a bus error, sets job-done
// [R5] Eight-bit divisor, reset zero, sets master SCL frequency
// [R6] Hardware sets job-done at end of operation; SCL held low meanwhile
// [R7] Job-done clears only by writing one, never by itself
// [R8] Clearing job-done starts the next bus operation
// [R9] With ack enabled, ACK own address, general call, received data
// [R10] Ack disabled: no acknowledge, detached; re-enable resumes recognition
// [R11] Start request issues START when bus free, else after STOP
// [R12] Software clears start request after START; hardware leaves it
// [R13] Master stop request makes STOP, then clears itself
// [R14] Slave stop request: no STOP, become unaddressed, release lines
// [R15] Data write with job-done low sets collision; with it high clears
// [R16] Interface enable hands SCL and SDA pins to the unit
// [R17] Interface enable low stops the unit at once, aborting transfers
// [R18] Reserved control bit 1 and status bit 2 read zero
// [R19] Interrupt asserted while job-done, irq enable and global enable
// [R20] Status bits 7..3 hold the code, read with the prescaler bits
// [R21] Software masks prescaler bits before comparing status codes
// [R22] Status bits 1..0 are read-write prescaler select
// [R23] Prescaler codes select division by 1, 4, 16, 64
// [R24] Status code updates the cycle after job-done rises
// [R25] Job-done clear: status shows the no-information code
// [R26] Own address in bits 7..1, bit 0 enables general call
// [R27] Writing zero to job-done leaves it unchanged
module tw_bus_control
   import tw_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [3:0]        byteenable,
   input  wire logic [31:0]       writedata,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   input  wire tw_pin_in_s        pins_in,
   output tw_pin_out_s            pins_out,
   output logic                   pins_owned,
   input  wire logic              cpu_global_ie,
   output logic                   irq
);

   // ==========================================================
   // State
   typedef struct packed {
      tw_state_e   st;
      logic [7:0]  divisor;
      logic        job_done;
      logic        ack_en;
      logic        start_req;
      logic        stop_req;
      logic        wcol;
      logic        enable;
      logic        irq_en;
      logic [1:0]  presc;
      logic [4:0]  status_code;
      logic [4:0]  pend_code;
      logic [7:0]  data;
      logic [7:0]  own_addr;
      logic        master;
      logic        slave;
      logic        tx;
      logic        addr_phase;
      logic        busy;
      logic        phase;
      logic        seen_rise;
      logic        nack;
      logic        ack_out;
      logic [3:0]  cnt;
      logic [15:0] timer;
      logic        scl_low;
      logic        sda_low;
      logic        scl_prev;
      logic        sda_prev;
      logic        rd_done;
      logic [31:0] rdata;
   } tw_core_s;

   tw_core_s   cur;
   tw_core_s   next_cur;
   logic [1:0] rst_sync;
   logic       rst_n;

   // ==========================================================
   // Reset release
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // ==========================================================
   // Bus decode and pin events
   logic        wr_ok;
   logic        wr_ctrl;
   logic        clr_done;
   logic        go;
   logic        rise;
   logic        fall;
   logic        start_det;
   logic        stop_det;
   logic        tick;
   logic        addr_match;
   logic        gcall;
   logic [15:0] half_len;

   assign wr_ok     = write && byteenable[0];
   assign wr_ctrl   = wr_ok && address == TW_OFS_CONTROL[ADDR_W-1:0];
   assign clr_done  = wr_ctrl && writedata[TW_CTL_DONE];
   assign go        = cur.job_done && clr_done;                                // [R8]
   assign rise      = pins_in.scl && !cur.scl_prev;
   assign fall      = !pins_in.scl && cur.scl_prev;
   assign start_det = cur.scl_prev && pins_in.scl && cur.sda_prev && !pins_in.sda;
   assign stop_det  = cur.scl_prev && pins_in.scl && !cur.sda_prev && pins_in.sda;
   assign half_len  = 16'(TW_HALF_BASE + cur.divisor * (16'h0001 << {cur.presc, 1'b0})); // [R5] [R23]
   assign tick      = cur.timer >= half_len - 16'h0001;
   assign gcall     = cur.data[7:1] == 7'h00 && cur.own_addr[0];                // [R26]
   assign addr_match = cur.data[7:1] == cur.own_addr[7:1] || gcall;             // [R1]

   // ==========================================================
   // Next state
   always_comb
   begin
      next_cur          = cur;
      next_cur.rd_done  = 1'b0;
      next_cur.scl_prev = pins_in.scl;
      next_cur.sda_prev = pins_in.sda;
      next_cur.timer    = tick ? 16'h0000 : 16'(cur.timer + 16'h0001);
      if (start_det)
         next_cur.busy = 1'b1;
      if (stop_det)
         next_cur.busy = 1'b0;
      // Register writes
      if (wr_ok && address == TW_OFS_DIVISOR[ADDR_W-1:0])
         next_cur.divisor = writedata[7:0];
      if (wr_ctrl)
      begin
         next_cur.ack_en    = writedata[TW_CTL_ACK];
         next_cur.start_req = writedata[TW_CTL_START];                          // [R12]
         next_cur.stop_req  = writedata[TW_CTL_STOP];
         next_cur.enable    = writedata[TW_CTL_EN];
         next_cur.irq_en    = writedata[TW_CTL_IRQEN];
         if (writedata[TW_CTL_DONE])
            next_cur.job_done = 1'b0;                                           // [R7] [R27]
      end
      if (wr_ok && address == TW_OFS_STATUS[ADDR_W-1:0])
         next_cur.presc = writedata[1:0];                                       // [R22]
      if (wr_ok && address == TW_OFS_DATA[ADDR_W-1:0])
      begin
         if (cur.job_done)
         begin
            next_cur.data = writedata[7:0];
            next_cur.wcol = 1'b0;                                               // [R15]
         end
         else
            next_cur.wcol = 1'b1;                                               // [R15]
      end
      if (wr_ok && address == TW_OFS_OWNADDR[ADDR_W-1:0])
         next_cur.own_addr = writedata[7:0];
      // Register reads
      if (read && !cur.rd_done)
      begin
         next_cur.rd_done = 1'b1;
         case (address)
            TW_OFS_DIVISOR[ADDR_W-1:0]: next_cur.rdata = {24'h00_0000, cur.divisor};
            TW_OFS_CONTROL[ADDR_W-1:0]: next_cur.rdata = {24'h00_0000, cur.job_done,
               cur.ack_en, cur.start_req, cur.stop_req, cur.wcol, cur.enable, 1'b0,
               cur.irq_en};                                                     // [R18]
            TW_OFS_STATUS[ADDR_W-1:0]:  next_cur.rdata = {24'h00_0000, cur.status_code,
               1'b0, cur.presc};                                                // [R18] [R20]
            TW_OFS_DATA[ADDR_W-1:0]:    next_cur.rdata = {24'h00_0000, cur.data};
            TW_OFS_OWNADDR[ADDR_W-1:0]: next_cur.rdata = {24'h00_0000, cur.own_addr};
            default:                    next_cur.rdata = 32'h0000_0000;
         endcase
      end
      // Status code follows the flag one cycle later
      next_cur.status_code = cur.job_done ? cur.pend_code : TW_SC_NO_INFO;      // [R24] [R25]
      // Protocol engine
      case (cur.st)
         TW_IDLE:
         begin
            next_cur.scl_low = 1'b0;
            next_cur.sda_low = 1'b0;
            next_cur.timer   = 16'h0000;
            if (cur.start_req && !cur.busy)                                     // [R11]
            begin
               next_cur.st    = TW_MSTART;
               next_cur.phase = 1'b0;
            end
            else if (start_det && cur.ack_en)                                   // [R10]
            begin
               next_cur.st         = TW_BYTE;
               next_cur.addr_phase = 1'b1;
               next_cur.tx         = 1'b0;
               next_cur.cnt        = 4'h0;
               next_cur.seen_rise  = 1'b0;
            end
         end
         TW_MSTART:
         begin
            if (!cur.phase)
            begin
               next_cur.scl_low = 1'b0;
               next_cur.sda_low = 1'b0;
               if (tick)
               begin
                  next_cur.phase   = 1'b1;
                  next_cur.sda_low = 1'b1;
               end
            end
            else if (tick)
            begin
               next_cur.scl_low    = 1'b1;
               next_cur.job_done   = 1'b1;                                      // [R6]
               next_cur.pend_code  = cur.master ? TW_SC_M_RSTART : TW_SC_M_START;
               next_cur.master     = 1'b1;
               next_cur.slave      = 1'b0;
               next_cur.addr_phase = 1'b1;
               next_cur.tx         = 1'b1;
               next_cur.st         = TW_WAIT;
            end
         end
         TW_BYTE:
         begin
            next_cur.scl_low = cur.master ? (tick ? !cur.scl_low : cur.scl_low) : 1'b0;
            if (start_det || stop_det)
            begin
               next_cur.job_done = 1'b1;
               next_cur.scl_low  = 1'b1;
               next_cur.sda_low  = 1'b0;
               next_cur.st       = TW_WAIT;
               if (cur.slave && !cur.addr_phase)
                  next_cur.pend_code = TW_SC_S_STOP;                            // [R3]
               else
               begin
                  next_cur.pend_code = TW_SC_BUS_ERR;                           // [R4]
                  next_cur.master    = 1'b0;
               end
               next_cur.slave = 1'b0;
            end
            else if (rise)
            begin
               next_cur.seen_rise = 1'b1;
               if (cur.cnt < TW_ACK_SLOT)
                  next_cur.data = {cur.data[6:0], pins_in.sda};
               else
                  next_cur.nack = pins_in.sda;
            end
            else if (fall && cur.seen_rise)
            begin
               next_cur.seen_rise = 1'b0;
               if (cur.cnt < TW_ACK_SLOT)
               begin
                  next_cur.cnt     = 4'(cur.cnt + 4'h1);
                  next_cur.sda_low = cur.tx && !cur.data[7];
                  if (cur.cnt == TW_ACK_SLOT - 4'h1)
                  begin
                     next_cur.ack_out = !cur.tx && cur.ack_en;                  // [R9]
                     if (!cur.master && cur.addr_phase && !(addr_match && cur.ack_en))
                     begin
                        next_cur.st    = TW_IDLE;                               // [R10]
                        next_cur.slave = 1'b0;
                     end
                     next_cur.sda_low = !cur.tx && cur.ack_en;                  // [R9]
                  end
               end
               else
               begin
                  next_cur.job_done   = 1'b1;                                   // [R1] [R2] [R6]
                  next_cur.scl_low    = 1'b1;
                  next_cur.sda_low    = 1'b0;
                  next_cur.cnt        = 4'h0;
                  next_cur.addr_phase = 1'b0;
                  next_cur.st         = TW_WAIT;
                  if (cur.master && cur.addr_phase)
                     next_cur.tx = !cur.data[0];
                  if (!cur.master && cur.addr_phase)
                  begin
                     next_cur.slave     = 1'b1;
                     next_cur.tx        = cur.data[0] && !gcall;
                     next_cur.pend_code = gcall ? TW_SC_S_GCALL : TW_SC_S_ADDR;
                  end
                  else if (cur.master && cur.tx)
                     next_cur.pend_code = cur.nack ? TW_SC_M_TX_NACK : TW_SC_M_TX_ACK;
                  else if (cur.master)
                     next_cur.pend_code = cur.ack_out ? TW_SC_M_RX_ACK : TW_SC_M_RX_NACK;
                  else if (cur.tx)
                     next_cur.pend_code = cur.nack ? TW_SC_S_TX_NACK : TW_SC_S_TX_ACK;
                  else
                     next_cur.pend_code = TW_SC_S_RX;
               end
            end
         end
         TW_WAIT:
         begin
            next_cur.scl_low = 1'b1;                                            // [R6]
            next_cur.timer   = 16'h0000;
            if (go)                                                             // [R8]
            begin
               next_cur.phase     = 1'b0;
               next_cur.cnt       = 4'h0;
               next_cur.seen_rise = 1'b0;
               if (next_cur.stop_req && cur.master)
               begin
                  next_cur.st      = TW_STOP;
                  next_cur.sda_low = 1'b1;
               end
               else if (next_cur.stop_req || (cur.slave && cur.tx && cur.nack))
               begin
                  next_cur.st       = TW_IDLE;                                  // [R14]
                  next_cur.slave    = 1'b0;
                  next_cur.stop_req = 1'b0;
                  next_cur.scl_low  = 1'b0;
                  next_cur.sda_low  = 1'b0;
               end
               else if (next_cur.start_req)
                  next_cur.st = cur.master ? TW_MSTART : TW_IDLE;
               else if (cur.master || cur.slave)
               begin
                  next_cur.st      = TW_BYTE;
                  next_cur.scl_low = cur.master;
                  next_cur.sda_low = cur.tx && !cur.data[7];
               end
               else
                  next_cur.st = TW_IDLE;
            end
         end
         TW_STOP:
         begin
            if (tick && !cur.phase)
            begin
               next_cur.phase   = 1'b1;
               next_cur.scl_low = 1'b0;
            end
            else if (tick)
            begin
               next_cur.sda_low  = 1'b0;
               next_cur.master   = 1'b0;
               next_cur.stop_req = 1'b0;                                        // [R13]
               next_cur.st       = TW_IDLE;
            end
         end
         default:
            next_cur.st = TW_IDLE;
      endcase
      if (!next_cur.enable)
      begin
         next_cur.st      = TW_IDLE;                                            // [R17]
         next_cur.master  = 1'b0;
         next_cur.slave   = 1'b0;
         next_cur.scl_low = 1'b0;
         next_cur.sda_low = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur             <= '0;
         cur.st          <= TW_IDLE;
         cur.divisor     <= TW_RST_DIVISOR;
         cur.presc       <= TW_RST_PRESC;
         cur.status_code <= TW_SC_NO_INFO;
         cur.pend_code   <= TW_SC_NO_INFO;
         cur.data        <= TW_RST_DATA;
         cur.own_addr    <= TW_RST_OWNADDR;
         cur.scl_prev    <= 1'b1;
         cur.sda_prev    <= 1'b1;
      end
      else
         cur <= next_cur;
   end

   // ==========================================================
   // Outputs
   assign readdata         = cur.rdata;
   assign waitrequest      = read && !cur.rd_done;
   assign pins_owned       = cur.enable;                                        // [R16]
   assign pins_out.scl_out = 1'b0;
   assign pins_out.sda_out = 1'b0;
   assign pins_out.scl_oe  = cur.enable && cur.scl_low;                         // [R16]
   assign pins_out.sda_oe  = cur.enable && cur.sda_low;
   assign irq              = cur.job_done && cur.irq_en && cpu_global_ie;       // [R19]

   // ==========================================================
   // Checks
   status_late_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R24]
      $rose(cur.job_done) |=> cur.status_code == $past(cur.pend_code))
      else $error("status code not updated after job-done");
   status_none_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R25]
      !cur.job_done && !$past(cur.job_done) |-> cur.status_code == TW_SC_NO_INFO)
      else $error("status code not idle while flag clear");
   scl_stretch_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
      cur.job_done && cur.enable && cur.st == TW_WAIT |-> pins_out.scl_oe)
      else $error("clock not held low while job-done");
   done_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
      $fell(cur.job_done) |-> $past(clr_done))
      else $error("job-done cleared without a written one");
   wcol_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
      wr_ok && address == TW_OFS_DATA[ADDR_W-1:0] && !cur.job_done |=> cur.wcol)
      else $error("write collision not flagged");
   off_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R17]
      !cur.enable |-> cur.st == TW_IDLE && !pins_out.scl_oe && !pins_out.sda_oe)
      else $error("unit active while disabled");
   rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R18]
      read && !cur.rd_done && (address == TW_OFS_CONTROL[ADDR_W-1:0]
      || address == TW_OFS_STATUS[ADDR_W-1:0]) |=> readdata[2:1] != 2'b11
      && (readdata[1] == 1'b0 || address == TW_OFS_STATUS[ADDR_W-1:0]))
      else $error("reserved bit reads one");
   start_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
      cur.st == TW_IDLE && cur.busy && !start_det |=> cur.st != TW_MSTART)
      else $error("start issued on busy bus");
   stop_done_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
      cur.st == TW_STOP ##1 cur.st == TW_IDLE |-> !cur.stop_req && !cur.master)
      else $error("stop request not cleared after stop");
   irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R19]
      cur.irq_en && cpu_global_ie && $rose(cur.job_done) |-> irq)
      else $error("interrupt missing with job-done");

endmodule

// ---- rtl/tw_pkg.sv ----
// Shared constants, register map and carrier types of the two-wire control block
package tw_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] TW_OFS_DIVISOR = 8'h00;
   localparam logic [7:0] TW_OFS_CONTROL = 8'h04;
   localparam logic [7:0] TW_OFS_STATUS  = 8'h08;
   localparam logic [7:0] TW_OFS_DATA    = 8'h0C;
   localparam logic [7:0] TW_OFS_OWNADDR = 8'h10;

   // ==========================================================
   // Control register fields
   localparam int TW_CTL_DONE  = 7;
   localparam int TW_CTL_ACK   = 6;
   localparam int TW_CTL_START = 5;
   localparam int TW_CTL_STOP  = 4;
   localparam int TW_CTL_WCOL  = 3;
   localparam int TW_CTL_EN    = 2;
   localparam int TW_CTL_RSVD  = 1;
   localparam int TW_CTL_IRQEN = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] TW_RST_DIVISOR = 8'h00;
   localparam logic [7:0] TW_RST_DATA    = 8'hFF;
   localparam logic [7:0] TW_RST_OWNADDR = 8'hFE;
   localparam logic [1:0] TW_RST_PRESC   = 2'h0;

   // ==========================================================
   // Status codes
   localparam logic [4:0] TW_SC_BUS_ERR   = 5'h00;
   localparam logic [4:0] TW_SC_M_START   = 5'h01;
   localparam logic [4:0] TW_SC_M_RSTART  = 5'h02;
   localparam logic [4:0] TW_SC_M_TX_ACK  = 5'h03;
   localparam logic [4:0] TW_SC_M_TX_NACK = 5'h04;
   localparam logic [4:0] TW_SC_M_RX_ACK  = 5'h05;
   localparam logic [4:0] TW_SC_M_RX_NACK = 5'h06;
   localparam logic [4:0] TW_SC_S_ADDR    = 5'h07;
   localparam logic [4:0] TW_SC_S_GCALL   = 5'h08;
   localparam logic [4:0] TW_SC_S_RX      = 5'h09;
   localparam logic [4:0] TW_SC_S_TX_ACK  = 5'h0A;
   localparam logic [4:0] TW_SC_S_TX_NACK = 5'h0B;
   localparam logic [4:0] TW_SC_S_STOP    = 5'h0C;
   localparam logic [4:0] TW_SC_NO_INFO   = 5'h1F;

   // ==========================================================
   // Timing
   localparam logic [15:0] TW_HALF_BASE = 16'h0008;
   localparam logic [3:0]  TW_ACK_SLOT  = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [4:0] {
      TW_IDLE   = 5'b00001,
      TW_MSTART = 5'b00010,
      TW_BYTE   = 5'b00100,
      TW_WAIT   = 5'b01000,
      TW_STOP   = 5'b10000
   } tw_state_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } tw_pin_in_s;

   typedef struct packed {
      logic scl_out;
      logic scl_oe;
      logic sda_out;
      logic sda_oe;
   } tw_pin_out_s;

endpackage

// ---- test/tw_far_end.sv ----
// Behavioural slave on the far side of the wire: acknowledges every byte
`timescale 1ns/100ps
module tw_far_end
(
   input  wire logic core_clk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      sda_oe
);
   logic       scl_d  = 1'b1;
   logic       sda_d  = 1'b1;
   logic [3:0] bits   = 4'h0;
   initial sda_oe = 1'b0;
   // ==========================================================
   // Edge watch and acknowledge
   always @(posedge core_clk)
   begin
      scl_d <= scl;
      sda_d <= sda;
      if (scl && scl_d && sda_d && !sda)
         bits <= 4'h0;
      else if (!scl_d && scl)
         bits <= bits + 4'h1;
      else if (scl_d && !scl)
      begin
         sda_oe <= (bits == 4'h8);
         if (bits == 4'h9)
            bits <= 4'h0;
      end
   end
endmodule

// ---- test/two_wire_bus_control_regs_bench.sv ----
// Register level bench of the two-wire control block
`timescale 1ns/100ps
module two_wire_bus_control_regs_bench;
   import tw_pkg::*;
   logic core_clk, arst_n, read, write, waitrequest, pins_owned, cpu_global_ie, irq, far_oe;
   logic [7:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, q;
   tw_pin_in_s pins_in;
   tw_pin_out_s pins_out;
   int err_count, checks;
   assign pins_in = '{scl: !pins_out.scl_oe, sda: !(pins_out.sda_oe || far_oe)};
   tw_bus_control dut_u (.core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .pins_in(pins_in), .pins_out(pins_out),
      .pins_owned(pins_owned), .cpu_global_ie(cpu_global_ie), .irq(irq));
   tw_far_end far_u (.core_clk(core_clk), .scl(pins_in.scl), .sda(pins_in.sda), .sda_oe(far_oe));
   // ==========================================================
   // Clock and tasks
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = !core_clk;
   end
   task automatic bus(input logic [7:0] a, input logic rd, input logic [7:0] d);
      int n;
      n = 0;
      address <= a;
      read <= rd;
      write <= !rd;
      writedata <= {24'h00_0000, d};
      do
      begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         err_count++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      bus(a, 1'b1, 8'h00);
      chk(nm, {24'h00_0000, e}, q);
   endtask
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         bus(TW_OFS_CONTROL, 1'b1, 8'h00);
         n++;
      end while (q[b] !== v && n < 200);
      chk("control poll bit", {31'h0, v}, {31'h0, q[b]});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      test_done();
   end
   // ==========================================================
   // Tests
   initial
   begin
      {arst_n, read, write, cpu_global_ie, address, writedata} = '0;
      byteenable = 4'hF;
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(TW_OFS_DIVISOR, 8'h00, "divisor");
      rd(TW_OFS_CONTROL, 8'h00, "control");
      rd(TW_OFS_STATUS, 8'hF8, "status");
      rd(TW_OFS_OWNADDR, 8'hFE, "own address");
      rd(8'h14, 8'h00, "unmapped");
      bus(TW_OFS_DIVISOR, 1'b0, 8'hA5);
      rd(TW_OFS_DIVISOR, 8'hA5, "divisor");
      bus(TW_OFS_DIVISOR, 1'b0, 8'h00);
      bus(TW_OFS_STATUS, 1'b0, 8'hFF);
      rd(TW_OFS_STATUS, 8'hFB, "status");
      bus(TW_OFS_STATUS, 1'b0, 8'h00);
      bus(TW_OFS_DATA, 1'b0, 8'h55);
      rd(TW_OFS_CONTROL, 8'h08, "collision");
      rd(TW_OFS_DATA, 8'hFF, "data");
      $display("registers done");
      cpu_global_ie <= 1'b1;
      bus(TW_OFS_CONTROL, 1'b0, 8'h25);
      chk("owned", 32'h1, {31'h0, pins_owned});
      poll(TW_CTL_DONE, 1'b1);
      rd(TW_OFS_STATUS, 8'h08, "start code");
      rd(TW_OFS_CONTROL, 8'hAD, "control");
      chk("scl held", 32'h1, {31'h0, pins_out.scl_oe});
      chk("irq", 32'h1, {31'h0, irq});
      bus(TW_OFS_CONTROL, 1'b0, 8'h05);
      rd(TW_OFS_CONTROL, 8'h8D, "control");
      bus(TW_OFS_DATA, 1'b0, 8'hA0);
      rd(TW_OFS_CONTROL, 8'h85, "collision");
      $display("start done");
      bus(TW_OFS_CONTROL, 1'b0, 8'h85);
      rd(TW_OFS_STATUS, 8'hF8, "status");
      poll(TW_CTL_DONE, 1'b1);
      rd(TW_OFS_STATUS, 8'h18, "address ack");
      cpu_global_ie <= 1'b0;
      @(posedge core_clk);
      chk("irq", 32'h0, {31'h0, irq});
      $display("byte done");
      bus(TW_OFS_CONTROL, 1'b0, 8'h94);
      poll(TW_CTL_STOP, 1'b0);
      rd(TW_OFS_CONTROL, 8'h04, "control");
      chk("bus free", 32'h0, {30'h0, pins_out.scl_oe, pins_out.sda_oe});
      bus(TW_OFS_CONTROL, 1'b0, 8'h00);
      chk("owned", 32'h0, {31'h0, pins_owned});
      $display("stop done");
      test_done();
   end
endmodule
